// file: verilog/register_write_queue.v
// Purpose: register write queue of a serial master io module
// Assumes: memory read port answers with rd_valid_i, one word per request
// Notes:   queue-owned registers are applied locally, others go out
`timescale 1ns/1ns
`default_nettype none
`include "rwq_defines.vh"
module register_write_queue #(
    parameter AW    = 32,
    parameter DW    = 32,
    parameter IDXW  = 8,
    parameter NSRC  = 16
) (
    input  wire            clk_i,          // clock, 50 MHz
    input  wire            rst_n_i,        // async reset, active low
    // processor register writes to queue registers
    input  wire            cpu_wr_i,       // processor write strobe
    input  wire [7:0]      cpu_addr_i,     // processor register offset
    input  wire [DW-1:0]   cpu_wdata_i,    // processor write data
    // memory fetch port
    output wire            rd_req_o,       // fetch request
    output reg  [AW-1:0]   rd_addr_o,      // fetch address
    input  wire            rd_valid_i,     // fetch data valid
    input  wire [DW-1:0]   rd_data_i,      // fetch data
    // register writes forwarded to the module
    output reg             reg_wr_o,       // write pulse
    output reg  [7:0]      reg_addr_o,     // write offset
    output reg  [DW-1:0]   reg_wdata_o,    // write data
    // transaction engine
    output reg             txn_start_o,    // command launch pulse
    input  wire            txn_busy_i,     // transaction in progress
    // external pause inputs
    input  wire [6:0]      ext_pause_i,    // gpio and other masters
    input  wire [1:0]      spi_buf_i,      // spi master buffer signals
    // status
    output wire            running_o,      // queue enabled
    output wire            paused_o,       // queue held by pause
    output wire            queue_pause_irq_o, // masked pause event
    output wire [7:0]      soft_flags_o,   // soft flag values
    output reg  [AW-1:0]   queue_fetch_pointer_o // fetch pointer
);
    // ****************************************
    // states
    // ****************************************
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_ADDR = 5'h02;
    localparam [4:0] S_DATA = 5'h04;
    localparam [4:0] S_APPLY = 5'h08;
    localparam [4:0] S_WAIT = 5'h10;

    reg [4:0]       state_r;
    reg [4:0]       state_nxt;
    reg             first_r;
    reg             wait_seen_r;
    reg [7:0]       ent_addr_r;
    reg [DW-1:0]    ent_data_r;
    reg             queue_run_enable_r;
    reg [NSRC-1:0]  pause_source_enables_r;
    reg [NSRC-1:0]  pause_irq_mask_r;
    reg [IDXW-1:0]  current_index_r;
    reg [IDXW-1:0]  end_index_r;

    // ****************************************
    // write source select
    // ****************************************
    wire            q_wr = (state_r == S_APPLY);
    wire            any_wr = cpu_wr_i | q_wr;
    wire [7:0]      w_addr = q_wr ? ent_addr_r : cpu_addr_i;
    wire [DW-1:0]   w_data = q_wr ? ent_data_r : cpu_wdata_i;
    wire            local_hit = (w_addr == `RWQ_OFS_FETCH_PTR) | (w_addr == `RWQ_OFS_RUN_CFG) |
                                (w_addr == `RWQ_OFS_PAUSE_EN) | (w_addr == `RWQ_OFS_IRQ_MASK) |
                                (w_addr == `RWQ_OFS_FLAG_SRT) | (w_addr == `RWQ_OFS_CUR_IDX) |
                                (w_addr == `RWQ_OFS_END_IDX);
    wire            ptr_wr = any_wr & (w_addr == `RWQ_OFS_FETCH_PTR);
    wire            srt_wr = any_wr & (w_addr == `RWQ_OFS_FLAG_SRT);
    wire            q_cmd = q_wr & (ent_addr_r == `RWQ_OFS_TXN_CMD);

    // ****************************************
    // soft flags and pause sources
    // ****************************************
    wire [NSRC-1:0] src;
    wire            pause_any;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_flag
            rwq_flag_bit u_flag (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .wr_i    (any_wr & (w_addr == `RWQ_OFS_FLAG_SRT) & 1'b0),
                .wdata_i (1'b0),
                .set_i   (srt_wr & w_data[`RWQ_SRT_SET_LSB+g]),
                .clr_i   (srt_wr & w_data[`RWQ_SRT_CLR_LSB+g]),
                .tgl_i   (srt_wr & w_data[`RWQ_SRT_TGL_LSB+g]),
                .flag_o  (soft_flags_o[g])
            );
        end
    endgenerate

    assign src[7:0]  = soft_flags_o;
    assign src[8]    = soft_flags_o[0] & spi_buf_i[0];
    assign src[9]    = soft_flags_o[1] & ~spi_buf_i[0];
    assign src[10]   = soft_flags_o[2] & spi_buf_i[1];
    assign src[11]   = soft_flags_o[3] & ~spi_buf_i[1];
    assign src[14:12] = soft_flags_o[6:4] & ext_pause_i[6:4];
    assign src[15]   = (current_index_r == end_index_r);

    rwq_pause_gate #(
        .NSRC (NSRC)
    ) u_gate (
        .src_i   (src),
        .en_i    (pause_source_enables_r),
        .mask_i  (pause_irq_mask_r),
        .pause_o (pause_any),
        .irq_o   (queue_pause_irq_o)
    );

    // external lanes 3:0 are unused; sources 11:8 use the spi pair above instead
    wire unused_ext = |ext_pause_i[3:0];

    // ****************************************
    // control registers
    // ****************************************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            queue_run_enable_r     <= 1'b0;
            pause_source_enables_r <= `RWQ_RST_EN;
            pause_irq_mask_r       <= `RWQ_RST_EN;
            current_index_r        <= {IDXW{1'b0}};
            end_index_r            <= {IDXW{1'b0}};
        end else if (any_wr) begin
            if (w_addr == `RWQ_OFS_RUN_CFG) begin
                queue_run_enable_r <= w_data[`RWQ_RUN_EN_BIT];
            end
            if (w_addr == `RWQ_OFS_PAUSE_EN) begin
                pause_source_enables_r <= w_data[NSRC-1:0];
            end
            if (w_addr == `RWQ_OFS_IRQ_MASK) begin
                pause_irq_mask_r <= w_data[NSRC-1:0];
            end
            if (w_addr == `RWQ_OFS_CUR_IDX) begin
                current_index_r <= w_data[IDXW-1:0];
            end
            if (w_addr == `RWQ_OFS_END_IDX) begin
                end_index_r <= w_data[IDXW-1:0];
            end
        end
    end

    // ****************************************
    // fetch sequencer
    // ****************************************
    wire can_fetch = queue_run_enable_r & (first_r | ~pause_any);

    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (can_fetch) begin
                    state_nxt = S_ADDR;
                end
            end
            S_ADDR: begin
                if (rd_valid_i) begin
                    state_nxt = S_DATA;
                end
            end
            S_DATA: begin
                if (rd_valid_i) begin
                    state_nxt = S_APPLY;
                end
            end
            S_APPLY: begin
                state_nxt = q_cmd ? S_WAIT : S_IDLE;
            end
            S_WAIT: begin
                if (wait_seen_r & ~txn_busy_i) begin
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    assign rd_req_o  = (state_r == S_ADDR) | (state_r == S_DATA);
    assign running_o = queue_run_enable_r;
    assign paused_o  = queue_run_enable_r & (state_r == S_IDLE) & ~first_r & pause_any;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r               <= S_IDLE;
            first_r               <= 1'b1;
            wait_seen_r           <= 1'b0;
            ent_addr_r            <= 8'h00;
            ent_data_r            <= {DW{1'b0}};
            rd_addr_o             <= `RWQ_RST_PTR;
            queue_fetch_pointer_o <= `RWQ_RST_PTR;
            reg_wr_o              <= 1'b0;
            reg_addr_o            <= 8'h00;
            reg_wdata_o           <= {DW{1'b0}};
            txn_start_o           <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            reg_wr_o    <= 1'b0;
            txn_start_o <= 1'b0;
            if (!queue_run_enable_r) begin
                first_r <= 1'b1;
            end else if (state_r == S_APPLY) begin
                first_r <= 1'b0;
            end
            if (state_r == S_IDLE && can_fetch) begin
                rd_addr_o <= queue_fetch_pointer_o;
            end
            if (state_r == S_ADDR && rd_valid_i) begin
                ent_addr_r <= {rd_data_i[7:2], 2'b00};
                rd_addr_o  <= rd_addr_o + `RWQ_WORD_BYTES;
            end
            if (state_r == S_DATA && rd_valid_i) begin
                ent_data_r <= rd_data_i;
            end
            if (ptr_wr) begin
                queue_fetch_pointer_o <= w_data[AW-1:0];
            end else if (state_r == S_DATA && rd_valid_i) begin
                queue_fetch_pointer_o <= queue_fetch_pointer_o + `RWQ_ENTRY_BYTES;
            end
            if (q_wr && !local_hit) begin
                reg_wr_o    <= 1'b1;
                reg_addr_o  <= ent_addr_r;
                reg_wdata_o <= ent_data_r;
                txn_start_o <= q_cmd;
            end
            if (state_r == S_APPLY) begin
                wait_seen_r <= 1'b0;
            end else if (state_r == S_WAIT && txn_busy_i) begin
                wait_seen_r <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// file: verilog/rwq_defines.vh
// Purpose: shared constants for the register write queue
// Assumes: word-addressed module register space, byte memory addresses
// Notes:   offsets are module register word offsets in bytes
`ifndef RWQ_DEFINES_VH
`define RWQ_DEFINES_VH

// ****************************************
// queue register offsets
// ****************************************
`define RWQ_OFS_FETCH_PTR      8'h00
`define RWQ_OFS_RUN_CFG        8'h04
`define RWQ_OFS_PAUSE_EN       8'h08
`define RWQ_OFS_IRQ_MASK       8'h0C
`define RWQ_OFS_FLAG_SRT       8'h10
`define RWQ_OFS_CUR_IDX        8'h14
`define RWQ_OFS_END_IDX        8'h18
`define RWQ_OFS_TXN_CMD        8'h1C

// ****************************************
// fields and reset values
// ****************************************
`define RWQ_SRT_SET_LSB        0
`define RWQ_SRT_CLR_LSB        8
`define RWQ_SRT_TGL_LSB        16
`define RWQ_RUN_EN_BIT         0
`define RWQ_ENTRY_BYTES        32'h0000_0008
`define RWQ_WORD_BYTES         32'h0000_0004
`define RWQ_RST_PTR            32'h0000_0000
`define RWQ_RST_FLAGS          8'h00
`define RWQ_RST_EN             16'h0000
`define RWQ_IDX_BIT            15

`endif

// file: verilog/rwq_flag_bit.v
// Purpose: one software flag with set, clear, toggle and direct write
// Assumes: set, clear and toggle are one-cycle pulses
// Notes:   set beats clear, clear beats toggle
`timescale 1ns/1ns
`default_nettype none
module rwq_flag_bit (
    input  wire clk_i,     // clock
    input  wire rst_n_i,   // async reset, active low
    input  wire wr_i,      // direct write strobe
    input  wire wdata_i,   // direct write value
    input  wire set_i,     // set strobe
    input  wire clr_i,     // clear strobe
    input  wire tgl_i,     // toggle strobe
    output reg  flag_o     // flag value
);
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end else if (tgl_i) begin
            flag_o <= ~flag_o;
        end else if (wr_i) begin
            flag_o <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// file: verilog/rwq_pause_gate.v
// Purpose: pause source combine and enable gate
// Assumes: external inputs synchronous to the clock
// Notes:   pure combinational
`timescale 1ns/1ns
`default_nettype none
module rwq_pause_gate #(
    parameter NSRC = 16
) (
    input  wire [NSRC-1:0] src_i,    // raw pause sources
    input  wire [NSRC-1:0] en_i,     // pause enables
    input  wire [NSRC-1:0] mask_i,   // interrupt mask
    output wire            pause_o,  // any enabled source active
    output wire            irq_o     // any masked source active
);
    assign pause_o = |(src_i & en_i);
    assign irq_o   = |(src_i & mask_i);
endmodule
`default_nettype wire

// file: tb/rwq_asserts.sv
// Purpose: port assertions for register_write_queue
// Assumes: one clock, async active-low reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
`include "rwq_defines.vh"
module rwq_asserts #(
    parameter AW = 32,
    parameter DW = 32
) (
    input wire logic          clk_i,                // clock
    input wire logic          rst_n_i,              // reset, active low
    input wire logic          cpu_wr_i,             // cpu write
    input wire logic [7:0]    cpu_addr_i,           // cpu offset
    input wire logic [DW-1:0] cpu_wdata_i,          // cpu data
    input wire logic          rd_req_o,             // fetch request
    input wire logic [AW-1:0] rd_addr_o,            // fetch address
    input wire logic          rd_valid_i,           // fetch valid
    input wire logic          reg_wr_o,             // forwarded write
    input wire logic [7:0]    reg_addr_o,           // forwarded offset
    input wire logic          txn_start_o,          // launch pulse
    input wire logic          txn_busy_i,           // transaction busy
    input wire logic          running_o,            // run enable
    input wire logic          paused_o,             // paused
    input wire logic [7:0]    soft_flags_o,         // flags
    input wire logic [AW-1:0] queue_fetch_pointer_o // pointer
);
    logic [7:0] f_set, f_clr, f_tgl;
    assign f_set = cpu_wdata_i[`RWQ_SRT_SET_LSB +: 8];
    assign f_clr = cpu_wdata_i[`RWQ_SRT_CLR_LSB +: 8];
    assign f_tgl = cpu_wdata_i[`RWQ_SRT_TGL_LSB +: 8];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_launch; txn_start_o; endsequence
    sequence s_hold; !rd_req_o [*3]; endsequence
    property p_start; $rose(rd_req_o) |-> running_o && rd_addr_o == queue_fetch_pointer_o; endproperty
    a_start: assert property (p_start) else $error("fetch start off pointer");
    property p_pair; rd_req_o && rd_valid_i && rd_addr_o == queue_fetch_pointer_o
        |=> rd_req_o && rd_addr_o == $past(rd_addr_o) + 32'h4; endproperty
    a_pair: assert property (p_pair) else $error("second word not fetched next");
    property p_step; rd_req_o && rd_valid_i && !cpu_wr_i && rd_addr_o == queue_fetch_pointer_o + 32'h4
        |=> queue_fetch_pointer_o == $past(queue_fetch_pointer_o) + 32'h8; endproperty
    a_step: assert property (p_step) else $error("pointer not raised by eight");
    property p_launch; s_launch |-> reg_wr_o && reg_addr_o == `RWQ_OFS_TXN_CMD; endproperty
    a_launch: assert property (p_launch) else $error("launch without command write");
    property p_hold; s_launch |=> s_hold; endproperty
    a_hold: assert property (p_hold) else $error("fetch right after launch");
    property p_busy; txn_busy_i |-> !rd_req_o; endproperty
    a_busy: assert property (p_busy) else $error("fetch during transaction");
    property p_next; reg_wr_o && !txn_start_o && running_o && !paused_o && !cpu_wr_i |=> rd_req_o; endproperty
    a_next: assert property (p_next) else $error("no fetch after plain write");
    property p_pause; running_o && $past(running_o) && paused_o && $past(paused_o) && !rd_req_o
        |=> !rd_req_o; endproperty
    a_pause: assert property (p_pause) else $error("fetch while paused");
    property p_flags; cpu_wr_i && !running_o && cpu_addr_i == `RWQ_OFS_FLAG_SRT |=> soft_flags_o ==
        ((($past(soft_flags_o) ^ $past(f_tgl)) & ~$past(f_clr)) | $past(f_set)); endproperty
    a_flags: assert property (p_flags) else $error("flag set clear toggle wrong");
endmodule
bind register_write_queue rwq_asserts #(.AW(AW), .DW(DW)) u_rwq_asserts (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_wr_i(cpu_wr_i), .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_valid_i(rd_valid_i),
    .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .txn_start_o(txn_start_o), .txn_busy_i(txn_busy_i),
    .running_o(running_o), .paused_o(paused_o), .soft_flags_o(soft_flags_o),
    .queue_fetch_pointer_o(queue_fetch_pointer_o));
`default_nettype wire

// file: tb/rwq_mem_model.sv
// Purpose: memory holding queue entries, plus a transaction engine
// Assumes: one word answered per request, after lat_i idle cycles
// Notes:   data line shows inverted junk outside valid cycles
`timescale 1ns/1ns
`default_nettype none
module rwq_mem_model (
    input  wire logic        clk_i,       // clock
    input  wire logic        rst_n_i,     // reset, active low
    input  wire logic        req_i,       // fetch request
    input  wire logic [31:0] addr_i,      // fetch address
    input  wire logic        txn_start_i, // launch pulse
    input  wire logic [3:0]  lat_i,       // answer latency
    output var  logic        valid_o,     // word valid
    output var  logic [31:0] data_o,      // word
    output wire logic        busy_o       // transaction busy
);
    logic [31:0] mem [0:15];
    logic [3:0]  wait_r;
    logic [2:0]  busy_r;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_o <= 1'b0;
            data_o  <= 32'hA5A5_5A5A;
            wait_r  <= 4'h0;
            busy_r  <= 3'h0;
        end else begin
            valid_o <= 1'b0;
            data_o  <= ~data_o;
            if (req_i && !valid_o) begin
                if (wait_r >= lat_i) begin
                    valid_o <= 1'b1;
                    data_o  <= mem[addr_i[5:2]];
                    wait_r  <= 4'h0;
                end else
                    wait_r <= wait_r + 4'h1;
            end
            if (txn_start_i)
                busy_r <= 3'h5;
            else if (busy_r != 3'h0)
                busy_r <= busy_r - 3'h1;
        end
    end
    assign busy_o = (busy_r != 3'h0);
endmodule
`default_nettype wire

// file: tb/tb_register_write_queue.sv
// Purpose: self-checking bench for register_write_queue
// Assumes: cpu writes only while the queue is stopped or paused
// Notes:   flag cases table-driven, queue runs hand-written
`timescale 1ns/1ns
`default_nettype none
`include "rwq_defines.vh"
module tb_register_write_queue;
    logic        clk_i, rst_n_i, cpu_wr_i;
    logic [7:0]  cpu_addr_i;
    logic [31:0] cpu_wdata_i;
    logic [6:0]  ext_pause_i;
    logic [1:0]  spi_buf_i;
    logic [3:0]  lat;
    wire         rd_req_o, rd_valid_i, reg_wr_o, txn_start_o, txn_busy_i, running_o, paused_o, irq;
    wire  [31:0] rd_addr_o, rd_data_i, reg_wdata_o, ptr;
    wire  [7:0]  reg_addr_o, soft_flags_o;
    int          error_cnt, checks_done, n_fwd, n_txn, n_skip, i;
    logic [7:0]  fwd_a [0:7];
    logic [31:0] fwd_d [0:7];
    logic [31:0] srt_w [0:4] = '{32'h0000_000F, 32'h0030_0003, 32'h0000_4040, 32'h00FF_0F00, 32'h0002_FF00};
    logic [7:0]  srt_e [0:4] = '{8'h0F, 8'h3F, 8'h7F, 8'h80, 8'h00};
    register_write_queue uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_wr_i(cpu_wr_i), .cpu_addr_i(cpu_addr_i),
        .cpu_wdata_i(cpu_wdata_i), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_valid_i(rd_valid_i),
        .rd_data_i(rd_data_i), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
        .txn_start_o(txn_start_o), .txn_busy_i(txn_busy_i), .ext_pause_i(ext_pause_i), .spi_buf_i(spi_buf_i),
        .running_o(running_o), .paused_o(paused_o), .queue_pause_irq_o(irq), .soft_flags_o(soft_flags_o),
        .queue_fetch_pointer_o(ptr));
    rwq_mem_model u_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(rd_req_o), .addr_i(rd_addr_o),
        .txn_start_i(txn_start_o), .lat_i(lat), .valid_o(rd_valid_i), .data_o(rd_data_i), .busy_o(txn_busy_i));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cpu_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cpu_wr_i <= 1'b1;
        cpu_addr_i <= a;
        cpu_wdata_i <= d;
        @(posedge clk_i);
        cpu_wr_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic wait_pause(input int n);
        int k;
        for (k = 0; k < 600 && !(n_fwd == n && paused_o === 1'b1 && rd_req_o === 1'b0); k++)
            @(negedge clk_i);
        repeat (20) @(negedge clk_i);
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // forwarded writes, launches and fetches of the skipped entry
    always @(posedge clk_i) begin
        if (reg_wr_o && n_fwd < 8) begin
            fwd_a[n_fwd] = reg_addr_o;
            fwd_d[n_fwd] = reg_wdata_o;
            n_fwd++;
        end
        if (txn_start_o) n_txn++;
        if (rd_req_o && rd_addr_o == 32'h0000_0028) n_skip++;
    end
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #(20 * 8000);
        error_cnt++;
        give_verdict;
    end
    initial begin
        {rst_n_i, cpu_wr_i, cpu_addr_i, cpu_wdata_i, ext_pause_i, spi_buf_i, lat} = '0;
        u_mem.mem = '{32'h20, 32'h1111_0001, 32'h1C, 32'hB2, 32'h24, 32'hCCCC_0003, 32'h10, 32'h1,
                      32'h00, 32'h30, 32'h2C, 32'h5555_0005, 32'h10, 32'h1, 32'h0, 32'h0};
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        check(ptr, 32'h0);
        check({running_o, rd_req_o, reg_wr_o, soft_flags_o}, 32'h0);
        for (i = 0; i < 5; i++) begin
            cpu_write(`RWQ_OFS_FLAG_SRT, srt_w[i]);
            check(soft_flags_o, srt_e[i]);
        end
        cpu_write(`RWQ_OFS_FLAG_SRT, 32'h0000_0012);
        cpu_write(`RWQ_OFS_IRQ_MASK, 32'h0000_0200);
        check(irq, 32'h1);
        @(posedge clk_i);
        spi_buf_i <= 2'b01;
        @(negedge clk_i);
        check(irq, 32'h0);
        cpu_write(`RWQ_OFS_IRQ_MASK, 32'h0000_1000);
        check(irq, 32'h0);
        @(posedge clk_i);
        ext_pause_i <= 7'h10;
        @(negedge clk_i);
        check(irq, 32'h1);
        cpu_write(`RWQ_OFS_IRQ_MASK, 32'h0000_8000);
        cpu_write(`RWQ_OFS_END_IDX, 32'h6);
        check(irq, 32'h0);
        cpu_write(`RWQ_OFS_CUR_IDX, 32'h6);
        check(irq, 32'h1);
        cpu_write(`RWQ_OFS_FETCH_PTR, 32'h0);
        cpu_write(`RWQ_OFS_PAUSE_EN, 32'h0000_0001);
        cpu_write(`RWQ_OFS_FLAG_SRT, 32'h0000_0001);
        cpu_write(`RWQ_OFS_RUN_CFG, 32'h1);
        wait_pause(1);
        check(n_fwd, 32'h1);
        check({fwd_a[0], fwd_d[0][23:0]}, 32'h2011_0001);
        check(ptr, 32'h8);
        @(posedge clk_i);
        lat <= 4'h3;
        cpu_write(`RWQ_OFS_FLAG_SRT, 32'h0000_0100);
        wait_pause(3);
        check(n_txn, 32'h1);
        check({fwd_a[1], fwd_d[1][23:0]}, 32'h1C00_00B2);
        check({fwd_a[2], fwd_d[2][23:0]}, 32'h24CC_0003);
        check(ptr, 32'h20);
        check(soft_flags_o, 32'h13);
        cpu_write(`RWQ_OFS_FLAG_SRT, 32'h0000_0100);
        wait_pause(3);
        check(ptr, 32'h38);
        check(n_skip, 32'h0);
        give_verdict;
    end
endmodule
`default_nettype wire
